// ---- src/ali_axis_regs.svh ----
// Register offsets, field positions, reset values and bit masks of the axis block.
// Assumes a 32-bit word port with byte offsets that are multiples of four.
`ifndef ALI_AXIS_REGS_SVH
`define ALI_AXIS_REGS_SVH

`define ALI_OFS_CTRL      8'h00
`define ALI_OFS_PLIM      8'h04
`define ALI_OFS_NLIM      8'h08
`define ALI_OFS_EVT_MASK  8'h0c
`define ALI_OFS_EVT_STAT  8'h10
`define ALI_OFS_ERR_STAT  8'h14
`define ALI_OFS_IDLE_CNT  8'h18
`define ALI_OFS_STATE     8'h1c

`define ALI_CTRL_INT_EN   0
`define ALI_CTRL_SL_EN    1
`define ALI_CTRL_SL_DECEL 2
`define ALI_CTRL_IDLE_EN  3

`define ALI_RST_PLIM      32'h7fffffff
`define ALI_RST_NLIM      32'h80000000
`define ALI_RST_MASK      32'h00000000
`define ALI_RST_IDLE      16'h0000

`define ALI_EVT_VALID     32'h0005dcf7
`define ALI_ERR_VALID     32'h0003f7eb
`define ALI_EVT_TRIG_BIT  12
`define ALI_EVT_LTC_BIT   14
`define ALI_ERR_SLP_BIT   0
`define ALI_ERR_SLN_BIT   1

`endif

// ---- src/ali_axis_pkg.sv ----
// Types shared by the axis limit, interrupt and idling logic.
// Assumes the offsets and masks of ali_axis_regs.svh.
package ali_axis_pkg;

    typedef enum logic [1:0] {
        ALI_IDLE_WAIT,
        ALI_IDLE_RUN,
        ALI_IDLE_ACCEL
    } ali_idle_st_t;

    typedef struct packed {
        logic idle_en;
        logic sl_decel;
        logic sl_en;
        logic int_en;
    } ali_ctrl_t;

    // Register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } ali_bus_req_t;

    // Start, position mode and speed ticks of a move as seen by the pulse generator
    typedef struct packed {
        logic start;
        logic accdec;
        logic pos_mode;
        logic sp_tick;
    } ali_move_t;

endpackage : ali_axis_pkg

// ---- src/ali_axis.sv ----
// Per-axis software limits, interrupt cause words and idling pulse stage.
// Assumes all inputs synchronous to i_ref_clk and cause inputs as one-cycle pulses.
`include "ali_axis_regs.svh"

module ali_axis #(
    parameter int AXIS_INDEX = 0
) (
    // Clock and reset
    input  wire logic                   i_ref_clk,
    input  wire logic                   i_reset_n,
    // Register port
    input  wire ali_axis_pkg::ali_bus_req_t i_bus,
    output logic [31:0]                 o_rdata,
    // Position and causes
    input  wire logic [31:0]            i_cmd_pos,
    input  wire logic [31:0]            i_evt_cause,
    input  wire logic [31:0]            i_err_cause,
    // Move and idling
    input  wire ali_axis_pkg::ali_move_t i_move,
    output logic                        o_hold_accel,
    output logic                        o_idle_pulse,
    output logic                        o_dist_credit,
    output logic                        o_accel_go,
    // Stop and interrupt
    output logic                        o_stop_now,
    output logic                        o_stop_decel,
    output logic                        o_irq
);
    import ali_axis_pkg::*;

    typedef struct packed {
        ali_ctrl_t    ctrl;
        logic [31:0]  plim;
        logic [31:0]  nlim;
        logic [31:0]  mask;
        logic [31:0]  evt;
        logic [31:0]  err;
        logic [15:0]  idle_cnt;
        logic [15:0]  idle_left;
        ali_idle_st_t st;
        logic         hit_p;
        logic         hit_n;
        logic [31:0]  rdata;
        logic         stop_now;
        logic         stop_decel;
        logic         irq;
        logic         idle_pulse;
        logic         dist_credit;
        logic         accel_go;
        logic         hold_accel;
    } ali_state_t;

    ali_state_t q;
    ali_state_t d;

    // Per-axis implemented event bits; trigger only on axes 0/1, latch on 2/3
    function automatic logic [31:0] evt_valid(input int axis);
        logic [31:0] m;
        m = `ALI_EVT_VALID;
        if (axis > 1) begin
            m[`ALI_EVT_TRIG_BIT] = 1'b0;
        end
        if (axis < 2) begin
            m[`ALI_EVT_LTC_BIT] = 1'b0;
        end
        return m;
    endfunction : evt_valid

    localparam logic [31:0] EVT_OK = evt_valid(AXIS_INDEX);

    logic        hit_p;
    logic        hit_n;
    logic        rd_evt;
    logic        rd_err;
    logic [31:0] evt_set;
    logic [31:0] err_set;

    // Signed compare against command position only
    assign hit_p  = q.ctrl.sl_en && ($signed(i_cmd_pos) >= $signed(q.plim));
    assign hit_n  = q.ctrl.sl_en && ($signed(i_cmd_pos) <= $signed(q.nlim));
    assign rd_evt = i_bus.rd && (i_bus.addr == `ALI_OFS_EVT_STAT);
    assign rd_err = i_bus.rd && (i_bus.addr == `ALI_OFS_ERR_STAT);

    always_comb begin
        // Event causes map straight onto their bit positions
        evt_set = i_evt_cause & EVT_OK;
        err_set = i_err_cause & `ALI_ERR_VALID;
        // Edge only, so a parked axis does not refill the word after each read
        err_set[`ALI_ERR_SLP_BIT] = hit_p && !q.hit_p;
        err_set[`ALI_ERR_SLN_BIT] = hit_n && !q.hit_n;
    end

    always_comb begin
        d = q;
        d.hit_p       = hit_p;
        d.hit_n       = hit_n;
        d.rdata       = 32'h00000000;
        d.idle_pulse  = 1'b0;
        d.dist_credit = 1'b0;
        d.accel_go    = 1'b0;

        // Register writes
        if (i_bus.wr) begin
            case (i_bus.addr)
                `ALI_OFS_CTRL:     d.ctrl = ali_ctrl_t'(i_bus.wdata[3:0]);
                `ALI_OFS_PLIM:     d.plim = i_bus.wdata;
                `ALI_OFS_NLIM:     d.nlim = i_bus.wdata;
                `ALI_OFS_EVT_MASK: d.mask = i_bus.wdata & EVT_OK;
                `ALI_OFS_IDLE_CNT: d.idle_cnt = i_bus.wdata[15:0];
                default:           d.plim = q.plim;
            endcase
        end

        // Register reads, data in the following cycle
        if (i_bus.rd) begin
            case (i_bus.addr)
                `ALI_OFS_CTRL:     d.rdata = {28'h0000000, q.ctrl};
                `ALI_OFS_PLIM:     d.rdata = q.plim;
                `ALI_OFS_NLIM:     d.rdata = q.nlim;
                `ALI_OFS_EVT_MASK: d.rdata = q.mask;
                `ALI_OFS_EVT_STAT: d.rdata = q.evt;
                `ALI_OFS_ERR_STAT: d.rdata = q.err;
                `ALI_OFS_IDLE_CNT: d.rdata = {16'h0000, q.idle_cnt};
                `ALI_OFS_STATE:    d.rdata = {26'h0000000, q.st, q.hit_n, q.hit_p,
                                              q.stop_now | q.stop_decel, q.irq};
                default:           d.rdata = 32'h00000000;
            endcase
        end

        // Sticky until read; a cause in the read cycle survives the clear
        d.evt = (rd_evt ? 32'h00000000 : q.evt) | evt_set;
        d.err = (rd_err ? 32'h00000000 : q.err) | err_set;

        // Limit reaction mirrors a hardware end limit
        d.stop_now   = (hit_p || hit_n) && !q.ctrl.sl_decel;
        d.stop_decel = (hit_p || hit_n) && q.ctrl.sl_decel;

        // Errors bypass the mask, events do not
        d.irq = q.ctrl.int_en && (|(q.evt & q.mask) || |q.err);

        // Idling stage ahead of acceleration
        case (q.st)
            ALI_IDLE_WAIT: begin
                if (i_move.start && i_move.accdec) begin
                    if (q.ctrl.idle_en && q.idle_cnt > 16'h0001) begin
                        d.st        = ALI_IDLE_RUN;
                        d.idle_left = q.idle_cnt - 16'h0001;
                    end else begin
                        d.st       = ALI_IDLE_ACCEL;
                        d.accel_go = 1'b1;
                    end
                end
            end
            ALI_IDLE_RUN: begin
                if (i_move.sp_tick) begin
                    d.idle_pulse  = 1'b1;
                    d.dist_credit = i_move.pos_mode;
                    d.idle_left   = q.idle_left - 16'h0001;
                    if (q.idle_left == 16'h0001) begin
                        d.st       = ALI_IDLE_ACCEL;
                        d.accel_go = 1'b1;
                    end
                end
            end
            ALI_IDLE_ACCEL: begin
                // A limit stop ends the move, as does the next start
                if (q.stop_now || q.stop_decel || i_move.start) begin
                    d.st = ALI_IDLE_WAIT;
                end
            end
            default: d.st = ALI_IDLE_WAIT;
        endcase
        // Registered copy of the state, so the pin is glitch free
        d.hold_accel = (d.st == ALI_IDLE_RUN);
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            q          <= '0;
            q.plim     <= `ALI_RST_PLIM;
            q.nlim     <= `ALI_RST_NLIM;
            q.mask     <= `ALI_RST_MASK;
            q.idle_cnt <= `ALI_RST_IDLE;
            q.st       <= ALI_IDLE_WAIT;
        end else begin
            q <= d;
        end
    end

    assign o_rdata       = q.rdata;
    assign o_hold_accel  = q.hold_accel;
    assign o_idle_pulse  = q.idle_pulse;
    assign o_dist_credit = q.dist_credit;
    assign o_accel_go    = q.accel_go;
    assign o_stop_now    = q.stop_now;
    assign o_stop_decel  = q.stop_decel;
    assign o_irq         = q.irq;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);

    property p_limit_off_quiet;
        !$past(q.ctrl.sl_en) |-> !o_stop_now && !o_stop_decel;
    endproperty
    a_limit_off_quiet: assert property (p_limit_off_quiet)
        else $error("limit stop while checking disabled");

    property p_plim_stop;
        q.ctrl.sl_en && !q.ctrl.sl_decel && ($signed(i_cmd_pos) >= $signed(q.plim))
            |=> o_stop_now && !o_stop_decel;
    endproperty
    a_plim_stop: assert property (p_plim_stop)
        else $error("positive limit did not stop axis");

    property p_nlim_decel;
        q.ctrl.sl_en && q.ctrl.sl_decel && ($signed(i_cmd_pos) <= $signed(q.nlim))
            |=> o_stop_decel && !o_stop_now;
    endproperty
    a_nlim_decel: assert property (p_nlim_decel)
        else $error("negative limit did not decelerate axis");

    property p_irq_gate;
        !q.ctrl.int_en |=> !o_irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt raised while disabled");

    property p_err_irq;
        q.ctrl.int_en && (q.err != 32'h0) |=> o_irq;
    endproperty
    a_err_irq: assert property (p_err_irq)
        else $error("error cause without interrupt");

    property p_masked_quiet;
        q.err == 32'h0 && (q.evt & q.mask) == 32'h0 |=> !o_irq;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet)
        else $error("interrupt from masked event");

    property p_slp_flag;
        hit_p && !q.hit_p |=> q.err[`ALI_ERR_SLP_BIT];
    endproperty
    a_slp_flag: assert property (p_slp_flag)
        else $error("positive limit stop not flagged");

    property p_reserved_zero;
        (q.evt & ~EVT_OK) == 32'h0 && (q.err & ~`ALI_ERR_VALID) == 32'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved status bit set");

    property p_sticky;
        !rd_evt |=> (q.evt & $past(q.evt)) == $past(q.evt);
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("event bit lost without read");

    property p_idle_load;
        q.st == ALI_IDLE_WAIT && i_move.start && i_move.accdec && q.ctrl.idle_en
            && q.idle_cnt > 16'h0001 |=> o_hold_accel && q.idle_left == $past(q.idle_cnt) - 1;
    endproperty
    a_idle_load: assert property (p_idle_load)
        else $error("idle count not loaded minus one");

    property p_idle_end;
        q.st == ALI_IDLE_RUN && i_move.sp_tick && q.idle_left == 16'h0001
            |=> o_idle_pulse && o_accel_go ##1 !o_hold_accel;
    endproperty
    a_idle_end: assert property (p_idle_end)
        else $error("acceleration not released after idling");

    property p_sln_flag;
        hit_n && !q.hit_n |=> q.err[`ALI_ERR_SLN_BIT];
    endproperty
    a_sln_flag: assert property (p_sln_flag)
        else $error("negative limit stop not flagged");

    property p_evt_cause_set;
        (i_evt_cause & EVT_OK) != 32'h0
            |=> (q.evt & $past(i_evt_cause) & EVT_OK) == ($past(i_evt_cause) & EVT_OK);
    endproperty
    a_evt_cause_set: assert property (p_evt_cause_set)
        else $error("event cause not recorded");

    property p_err_cause_set;
        (i_err_cause & `ALI_ERR_VALID & ~32'h3) != 32'h0
            |=> (q.err & $past(i_err_cause) & `ALI_ERR_VALID & ~32'h3)
                == ($past(i_err_cause) & `ALI_ERR_VALID & ~32'h3);
    endproperty
    a_err_cause_set: assert property (p_err_cause_set)
        else $error("error cause not recorded");

    property p_err_sticky;
        !rd_err |=> (q.err & $past(q.err)) == $past(q.err);
    endproperty
    a_err_sticky: assert property (p_err_sticky)
        else $error("error bit lost without read");

    property p_idle_credit;
        q.st == ALI_IDLE_RUN && i_move.sp_tick
            |=> o_idle_pulse && (o_dist_credit == $past(i_move.pos_mode));
    endproperty
    a_idle_credit: assert property (p_idle_credit)
        else $error("idle pulse not credited to the move");

    property p_no_idle;
        q.st == ALI_IDLE_WAIT && i_move.start && i_move.accdec && !q.ctrl.idle_en
            |=> o_accel_go && !o_hold_accel;
    endproperty
    a_no_idle: assert property (p_no_idle)
        else $error("idling while disabled");

    property p_rdata_idle;
        !i_bus.rd |=> o_rdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside read cycle");

    c_irq_rise:   cover property (!o_irq ##1 o_irq);
    c_stop_now:   cover property (o_stop_now);
    c_idle_accel: cover property (o_hold_accel ##[1:20] o_accel_go);
    c_read_clear: cover property (rd_err && q.err != 32'h0);
    c_idle_credit: cover property (o_dist_credit);

endmodule : ali_axis

// ---- verification/ali_host_model.sv ----
// Host side register master with one-cycle write and read strobes.
// Assumes read data stand only in the cycle after the read strobe.
module ali_host_model (
    // Clock
    input  wire logic                   i_ref_clk,
    // Register port
    output ali_axis_pkg::ali_bus_req_t  o_bus,
    input  wire logic [31:0]            i_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    import ali_axis_pkg::*;
    // Idle cycles before each access, slow host
    int gap = 0;
    initial o_bus = '0;
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        repeat (gap) @(posedge i_ref_clk);
        @(posedge i_ref_clk);
        o_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_ref_clk);
        // Released lines show inverted junk, not the old value
        o_bus <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        repeat (gap) @(posedge i_ref_clk);
        @(posedge i_ref_clk);
        o_bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge i_ref_clk);
        o_bus <= '{addr: ~a, wdata: 32'hffffffff, wr: 1'b0, rd: 1'b0};
        #1 d = i_rdata;
    endtask : reg_rd
endmodule : ali_host_model

// ---- verification/testbench.sv ----
// Self-checking bench of the axis limit, interrupt and idling block.
// Assumes axis index 0 and the host model on the register port.
`include "ali_axis_regs.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; \
    $display("Error %0t: got %h expected %h", $time, (a), (e)); end end

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import ali_axis_pkg::*;
    logic         ref_clk;
    logic         reset_n;
    ali_bus_req_t bus;
    ali_move_t    mv;
    logic [31:0]  rdata, cmd_pos, evt, err, ev, er, mask;
    logic         hold, idle_p, credit, go, stop_now, stop_dec, irq;
    logic [7:0]   n_idle, n_cred, n_go;
    int           failures = 0;
    int           checks = 0;
    int           seed = 32'h59a6;

    ali_host_model host (.i_ref_clk(ref_clk), .o_bus(bus), .i_rdata(rdata));
    ali_axis #(.AXIS_INDEX(0)) dut (
        .i_ref_clk(ref_clk), .i_reset_n(reset_n), .i_bus(bus), .o_rdata(rdata),
        .i_cmd_pos(cmd_pos), .i_evt_cause(evt), .i_err_cause(err), .i_move(mv),
        .o_hold_accel(hold), .o_idle_pulse(idle_p), .o_dist_credit(credit),
        .o_accel_go(go), .o_stop_now(stop_now), .o_stop_decel(stop_dec), .o_irq(irq));

    function automatic logic [31:0] exp_evt(input logic [31:0] c);
        // Latch bit belongs to axes 2 and 3 only
        return c & `ALI_EVT_VALID & ~(32'h1 << `ALI_EVT_LTC_BIT);
    endfunction : exp_evt
    function automatic logic [31:0] exp_err(input logic [31:0] c);
        return c & `ALI_ERR_VALID & ~32'h3;
    endfunction : exp_err
    function automatic logic [7:0] exp_idle(input logic [15:0] c, input logic en);
        return (en && c > 16'h1) ? c[7:0] - 8'h1 : 8'h0;
    endfunction : exp_idle

    always @(posedge ref_clk) begin
        n_idle <= n_idle + {7'h0, idle_p};
        n_cred <= n_cred + {7'h0, credit};
        n_go   <= n_go + {7'h0, go};
    end

    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    task automatic do_reset(input int n);
        @(posedge ref_clk);
        reset_n <= 1'b0;
        repeat (n) @(posedge ref_clk);
        reset_n <= 1'b1;
    endtask : do_reset

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        host.reg_rd(a, d);
        `CHK(d, e)
    endtask : chk_rd

    task automatic pulse(input logic [31:0] v, input logic [31:0] r);
        @(posedge ref_clk);
        evt <= v;
        err <= r;
        @(posedge ref_clk);
        evt <= 32'h0;
        err <= 32'h0;
    endtask : pulse

    task automatic lim(input logic [31:0] p, input logic [3:0] c, input logic sn,
                       input logic sd, input logic [31:0] e);
        host.reg_wr(`ALI_OFS_CTRL, {28'h0, c});
        @(posedge ref_clk);
        cmd_pos <= p;
        repeat (3) @(posedge ref_clk);
        #1;
        `CHK({stop_now, stop_dec}, {sn, sd})
        `CHK(irq, c[0] && e != 32'h0)
        chk_rd(`ALI_OFS_ERR_STAT, e);
        @(posedge ref_clk);
        cmd_pos <= 32'h0;
        repeat (2) @(posedge ref_clk);
    endtask : lim

    task automatic idle_run(input logic [15:0] cnt, input logic en, input logic pm);
        // Reset in mid-run also brings the idling stage back to wait
        do_reset(2);
        host.reg_wr(`ALI_OFS_IDLE_CNT, {16'h0, cnt});
        host.reg_wr(`ALI_OFS_CTRL, {28'h0, en, 3'h0});
        #1;
        n_idle <= 8'h0;
        n_cred <= 8'h0;
        n_go <= 8'h0;
        @(posedge ref_clk);
        mv <= '{start: 1'b1, accdec: 1'b1, pos_mode: pm, sp_tick: 1'b0};
        @(posedge ref_clk);
        // Position mode is a level and keeps its value pm for the whole move
        mv <= '{start: 1'b0, accdec: 1'b0, pos_mode: pm, sp_tick: 1'b0};
        #1;
        `CHK(hold, en && cnt > 16'h1)
        repeat (4) begin
            repeat (2) @(posedge ref_clk);
            mv.sp_tick <= 1'b1;
            @(posedge ref_clk);
            mv.sp_tick <= 1'b0;
        end
        repeat (2) @(posedge ref_clk);
        #1;
        `CHK(n_idle, exp_idle(cnt, en))
        `CHK(n_cred, pm ? exp_idle(cnt, en) : 8'h0)
        `CHK(n_go, 8'h1)
        `CHK(hold, 1'b0)
        chk_rd(`ALI_OFS_IDLE_CNT, {16'h0, cnt});
        chk_rd(`ALI_OFS_STATE, 32'h20);
    endtask : idle_run

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (5000) @(posedge ref_clk);
        failures++;
        complete_run;
    end

    initial begin
        reset_n = 1'b0;
        cmd_pos = 32'h0;
        evt = 32'h0;
        err = 32'h0;
        mv = '0;
        do_reset(20);
        chk_rd(`ALI_OFS_CTRL, 32'h0);
        chk_rd(`ALI_OFS_PLIM, `ALI_RST_PLIM);
        chk_rd(`ALI_OFS_NLIM, `ALI_RST_NLIM);
        chk_rd(`ALI_OFS_EVT_MASK, `ALI_RST_MASK);
        chk_rd(`ALI_OFS_ERR_STAT, 32'h0);
        chk_rd(8'h40, 32'h0);
        host.reg_wr(`ALI_OFS_PLIM, 32'h64);
        host.reg_wr(`ALI_OFS_NLIM, 32'hffffff9c);
        lim(32'h63, 4'h3, 1'b0, 1'b0, 32'h0);
        lim(32'h64, 4'h3, 1'b1, 1'b0, 32'h1);
        lim(32'hffffff9c, 4'h7, 1'b0, 1'b1, 32'h2);
        lim(32'hffffff38, 4'h1, 1'b0, 1'b0, 32'h0);
        // Error causes while interrupts are off: recorded, no request
        host.reg_wr(`ALI_OFS_CTRL, 32'h0);
        pulse(32'h0, 32'hffffffff);
        repeat (3) @(posedge ref_clk);
        #1;
        `CHK(irq, 1'b0)
        host.reg_wr(`ALI_OFS_CTRL, 32'h1);
        repeat (2) @(posedge ref_clk);
        #1;
        `CHK(irq, 1'b1)
        chk_rd(`ALI_OFS_ERR_STAT, exp_err(32'hffffffff));
        for (int i = 0; i < 8; i++) begin
            ev = $random(seed);
            er = (i < 4) ? 32'h0 : $random(seed);
            mask = (i == 0) ? 32'h0 : $random(seed);
            host.gap = i % 3;
            host.reg_wr(`ALI_OFS_EVT_MASK, mask);
            chk_rd(`ALI_OFS_EVT_MASK, mask & exp_evt(32'hffffffff));
            pulse(ev, er);
            repeat (2) @(posedge ref_clk);
            #1;
            `CHK(irq, |(exp_evt(ev) & mask) || |exp_err(er))
            chk_rd(`ALI_OFS_EVT_STAT, exp_evt(ev));
            chk_rd(`ALI_OFS_ERR_STAT, exp_err(er));
            repeat (2) @(posedge ref_clk);
            #1;
            `CHK(irq, 1'b0)
        end
        host.gap = 0;
        idle_run(16'h3, 1'b1, 1'b1);
        idle_run(16'h2, 1'b1, 1'b0);
        idle_run(16'h1, 1'b1, 1'b1);
        idle_run(16'h3, 1'b0, 1'b1);
        complete_run;
    end
endmodule : testbench
